// ---- bit_manipulation_unit_bench.sv ----
// Self-checking bench for the bit-manipulation unit
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_unit_bench;
    import bmu_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic mem_ack_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    logic [7:0] mem_byte = 8'h00;
    bmu_req_t req = '0;
    logic req_ready_o, done_o, err_o, mem_req_o, mem_we_o;
    bmu_res_t res_o;
    logic [15:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    int fail_count = 0, n_compared = 0, dly = 0, cnt = 0, wr_n = 0;
    bmu_bit_unit uut (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_i(req), .done_o, .err_o, .res_o,
        .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i);
    initial forever #4 clk_i = ~clk_i;
    // Byte memory answering after dly idle cycles
    always @(negedge clk_i) begin
        if (mem_req_o && !mem_ack_i && cnt >= dly) begin
            mem_ack_i <= 1'b1;
            mem_rdata_i <= mem_byte;
            cnt <= 0;
        end else begin
            mem_ack_i <= 1'b0;
            mem_rdata_i <= ~mem_rdata_i;
            cnt <= mem_req_o ? cnt + 1 : 0;
        end
    end
    always @(posedge clk_i) begin
        if (mem_req_o && mem_ack_i && mem_we_o) begin
            mem_byte <= mem_wdata_o;
            wr_n <= wr_n + 1;
        end
    end
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Returns {byte, carry, zero}
    function automatic logic [9:0] ref_f(bmu_op_t op, logic [7:0] d, logic [2:0] p, logic c);
        logic b;
        b = d[p];
        case (op)
            set_bit_op: d[p] = 1'b1;
            clear_bit_op: d[p] = 1'b0;
            invert_bit_op: d[p] = !b;
            bit_store_op: d[p] = c;
            bit_store_inverted_op: d[p] = !c;
            carry_and_op: c = c & b;
            carry_and_inverted_op: c = c & !b;
            carry_or_op: c = c | b;
            carry_or_inverted_op: c = c | !b;
            carry_xor_op: c = c ^ b;
            carry_xor_inverted_op: c = c ^ !b;
            bit_load_op: c = b;
            bit_load_inverted_op: c = !b;
            default: ;
        endcase
        return {d, c, !b};
    endfunction : ref_f
    task automatic run(bmu_op_t op, logic pfr, logic [2:0] p, logic mem, logic [7:0] d, logic c);
        logic [9:0] e;
        logic ill, wr, cy;
        int n, w0;
        e = ref_f(op, d, p, c);
        ill = pfr && (op inside {carry_and_inverted_op, carry_or_inverted_op, carry_xor_inverted_op,
            bit_load_inverted_op, bit_store_inverted_op});
        wr = op <= invert_bit_op || op >= bit_store_op;
        cy = op >= carry_and_op && op <= bit_load_inverted_op;
        @(negedge clk_i);
        mem_byte = d;
        w0 = wr_n;
        req = '{op: op, pos_from_reg: pfr, imm_pos: pfr ? ~p : p, pos_reg: {5'h15, pfr ? p : ~p}, in_mem: mem,
            addr: {13'h0a5c, p}, reg_data: mem ? ~d : d, carry: c, zero: !e[0]};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && err_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        check(err_o, ill);
        check(done_o, !ill);
        if (!ill && mem) check(mem_byte, e[9:2]);
        if (!ill && mem) check(8'(wr_n - w0), wr);
        if (!ill && !mem && wr) check(res_o.data, e[9:2]);
        if (!ill && !mem) check(res_o.reg_we, wr);
        if (!ill && cy) check({res_o.carry_we, res_o.carry}, {1'b1, e[1]});
        if (!ill) check({res_o.carry_we, res_o.zero_we}, {cy, op == test_bit_op});
        if (!ill && op == test_bit_op) check({res_o.zero_we, res_o.zero}, {1'b1, e[0]});
    endtask : run
    task automatic t_bits();
        for (int p = 0; p < 8; p++) begin
            for (int k = 0; k < 4; k++) begin
                run(bmu_op_t'(k), 1'b0, 3'(p), 1'b0, 8'ha5, 1'b0);
                run(bmu_op_t'(k), 1'b1, 3'(p), 1'b0, 8'h3c, 1'b1);
            end
        end
        $display("bit set, clear, invert and test finished");
    endtask : t_bits
    task automatic t_carry();
        for (int k = 4; k < 14; k++) begin
            for (int i = 0; i < 8; i++) begin
                run(bmu_op_t'(k), 1'b0, 3'(i * 3), 1'b0, i[1] ? 8'h01 << 3'(i * 3) : ~(8'h01 << 3'(i * 3)), i[0]);
            end
        end
        $display("carry, load and store finished");
    endtask : t_carry
    task automatic t_illegal();
        for (int k = 5; k < 14; k += 2) begin
            run(bmu_op_t'(k), 1'b1, 3'(k), 1'b0, 8'h0f, 1'b1);
        end
        run(carry_xor_op, 1'b1, 3'h7, 1'b0, 8'h80, 1'b0);
        $display("register position refusals finished");
    endtask : t_illegal
    task automatic t_mem();
        for (int k = 0; k < 14; k++) begin
            dly = k % 3;
            run(bmu_op_t'(k), 1'b0, 3'(k), 1'b1, 8'h96, k[0]);
        end
        $display("memory operand finished");
    endtask : t_mem
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        t_bits();
        t_carry();
        t_illegal();
        t_mem();
        end_sim();
    end
endmodule : bit_manipulation_unit_bench
`default_nettype wire

// ---- bmu_bit_alu.sv ----
// Combinational single-bit operation on one byte and the carry flag
`timescale 1ns/1ps
`default_nettype none
module bmu_bit_alu (
    // Operands
    input wire bmu_pkg::bmu_op_t op_i,
    input wire logic [bmu_pkg::BMU_BYTE_W-1:0] data_i,
    input wire logic [bmu_pkg::BMU_POS_W-1:0] pos_i,
    input wire logic carry_i,
    input wire logic zero_i,
    // Results
    output logic [bmu_pkg::BMU_BYTE_W-1:0] data_o,
    output logic carry_o,
    output logic zero_o
);
    import bmu_pkg::*;

    logic [BMU_BYTE_W-1:0] mask;
    logic bit_val;

    assign mask = bmu_mask(pos_i);
    assign bit_val = |(data_i & mask);

    always_comb begin
        data_o = data_i;
        carry_o = carry_i;
        zero_o = zero_i;
        unique case (op_i)
            set_bit_op: data_o = data_i | mask;
            clear_bit_op: data_o = data_i & ~mask;
            invert_bit_op: data_o = data_i ^ mask;
            test_bit_op: zero_o = ~bit_val;
            carry_and_op: carry_o = carry_i & bit_val;
            carry_and_inverted_op: carry_o = carry_i & ~bit_val;
            carry_or_op: carry_o = carry_i | bit_val;
            carry_or_inverted_op: carry_o = carry_i | ~bit_val;
            carry_xor_op: carry_o = carry_i ^ bit_val;
            carry_xor_inverted_op: carry_o = carry_i ^ ~bit_val;
            bit_load_op: carry_o = bit_val;
            bit_load_inverted_op: carry_o = ~bit_val;
            bit_store_op: data_o = carry_i ? (data_i | mask) : (data_i & ~mask);
            bit_store_inverted_op: data_o = carry_i ? (data_i & ~mask) : (data_i | mask);
            default: begin
                data_o = data_i;
                carry_o = carry_i;
                zero_o = zero_i;
            end
        endcase
    end

endmodule : bmu_bit_alu
`default_nettype wire

// ---- bmu_bit_unit.sv ----
// Bit-manipulation unit: request handshake, memory read-modify-write and result registers
//
// Contract
// - Set-bit forces the selected operand bit to one, others unchanged.
// - Clear-bit forces the selected operand bit to zero, others unchanged.
// - Invert-bit complements the selected operand bit, others unchanged.
// - Test-bit loads zero flag with the complement of the selected bit.
// - Set, clear, invert, test take position from immediate or register low bits.
// - Inverted carry, load and store forms take position only from immediate.
// - Carry-AND writes carry AND selected bit into carry.
// - Inverted carry-AND writes carry AND inverted bit into carry.
// - Carry-OR writes carry OR selected bit into carry.
// - Inverted carry-OR writes carry OR inverted bit into carry.
// - Carry-XOR writes carry XOR selected bit into carry.
// - Inverted carry-XOR writes carry XOR inverted bit into carry.
// - Bit-load copies the selected bit into carry, operand untouched.
// - Inverted bit-load copies the inverted selected bit into carry.
// - Bit-store writes carry into the selected bit, others intact.
// - Inverted bit-store writes inverted carry into the selected bit.
// - All operations act on one byte; positions span its eight bits.
`timescale 1ns/1ps
`default_nettype none
module bmu_bit_unit (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request from the instruction decoder
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire bmu_pkg::bmu_req_t req_i,
    // Completion
    output logic done_o,
    output logic err_o,
    output bmu_pkg::bmu_res_t res_o,
    // Byte memory port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [bmu_pkg::BMU_ADDR_W-1:0] mem_addr_o,
    output logic [bmu_pkg::BMU_BYTE_W-1:0] mem_wdata_o,
    input wire logic [bmu_pkg::BMU_BYTE_W-1:0] mem_rdata_i,
    input wire logic mem_ack_i
);
    import bmu_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_EXEC,
        ST_WRITE
    } bmu_state_t;

    bmu_state_t state;
    bmu_op_t op;
    logic in_mem;
    logic [BMU_POS_W-1:0] pos;
    logic [BMU_BYTE_W-1:0] op_byte;
    logic carry;
    logic zero;
    logic [BMU_POS_W-1:0] sel_pos;
    logic pos_legal;
    logic [BMU_BYTE_W-1:0] alu_data;
    logic alu_carry;
    logic alu_zero;
    logic accept;
    logic finish;

    bmu_pos_sel u_pos_sel (
        .op_i(req_i.op),
        .pos_from_reg_i(req_i.pos_from_reg),
        .imm_pos_i(req_i.imm_pos),
        .pos_reg_i(req_i.pos_reg),
        .pos_o(sel_pos),
        .legal_o(pos_legal)
    );

    bmu_bit_alu u_bit_alu (
        .op_i(op),
        .data_i(op_byte),
        .pos_i(pos),
        .carry_i(carry),
        .zero_i(zero),
        .data_o(alu_data),
        .carry_o(alu_carry),
        .zero_o(alu_zero)
    );

    assign req_ready_o = (state == ST_IDLE);
    assign accept = req_valid_i && req_ready_o;
    // Finishes in EXEC unless a memory byte must still be written back
    assign finish = ((state == ST_EXEC) && !(in_mem && bmu_writes_operand(op)))
        || ((state == ST_WRITE) && mem_ack_i);

    // Sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (accept && pos_legal) begin
                        state <= req_i.in_mem ? ST_READ : ST_EXEC;
                    end
                end
                ST_READ: begin
                    if (mem_ack_i) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= (in_mem && bmu_writes_operand(op)) ? ST_WRITE : ST_IDLE;
                end
                ST_WRITE: begin
                    if (mem_ack_i) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Captured request and operand byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            op <= set_bit_op;
            in_mem <= 1'b0;
            pos <= BMU_POS_RST;
            op_byte <= BMU_BYTE_RST;
            carry <= 1'b0;
            zero <= 1'b0;
        end else if (accept && pos_legal) begin
            op <= req_i.op;
            in_mem <= req_i.in_mem;
            pos <= sel_pos;
            op_byte <= req_i.reg_data;
            carry <= req_i.carry;
            zero <= req_i.zero;
        end else if ((state == ST_READ) && mem_ack_i) begin
            op_byte <= mem_rdata_i;
        end
    end

    // Memory port: read the byte, then, for operations that change the operand, write the whole modified byte to the same address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= BMU_ADDR_RST;
            mem_wdata_o <= BMU_BYTE_RST;
        end else if (accept && pos_legal && req_i.in_mem) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= req_i.addr;
        end else if ((state == ST_EXEC) && in_mem && bmu_writes_operand(op)) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_wdata_o <= alu_data;
        end else if (((state == ST_READ) || (state == ST_WRITE)) && mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
        end
    end

    // Results and completion pulses
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_o <= BMU_RES_RST;
            done_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            done_o <= finish;
            err_o <= accept && !pos_legal;
            if (finish) begin
                res_o.data <= alu_data;
                res_o.carry <= alu_carry;
                res_o.zero <= alu_zero;
                res_o.reg_we <= !in_mem && bmu_writes_operand(op);
                res_o.carry_we <= bmu_writes_carry(op);
                res_o.zero_we <= (op == test_bit_op);
            end
        end
    end

endmodule : bmu_bit_unit
`default_nettype wire

// ---- bmu_bit_unit_properties.sv ----
// Concurrent checks on the ports of the bit-manipulation unit
`timescale 1ns/1ps
`default_nettype none
module bmu_bit_unit_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and completion
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire bmu_pkg::bmu_req_t req_i,
    input wire logic done_o,
    input wire logic err_o,
    input wire bmu_pkg::bmu_res_t res_o,
    // Memory port
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [bmu_pkg::BMU_ADDR_W-1:0] mem_addr_o,
    input wire logic mem_ack_i
);
    import bmu_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [2:0] pos = req_i.pos_from_reg ? req_i.pos_reg[2:0] : req_i.imm_pos;
    wire bit_v = req_i.reg_data[pos];
    wire acc = req_valid_i && req_ready_o;
    wire bad = req_i.pos_from_reg && bmu_imm_only(req_i.op);
    wire acc_reg = acc && !bad && !req_i.in_mem;
    logic [7:0] exp_d;
    logic exp_c;
    logic [15:0] addr_q;
    // Reference byte and carry for a register operand
    always_comb begin
        exp_d = req_i.reg_data;
        exp_c = req_i.carry;
        case (req_i.op)
            set_bit_op: exp_d[pos] = 1'b1;
            clear_bit_op: exp_d[pos] = 1'b0;
            invert_bit_op: exp_d[pos] = !bit_v;
            bit_store_op: exp_d[pos] = req_i.carry;
            bit_store_inverted_op: exp_d[pos] = !req_i.carry;
            carry_and_op: exp_c = req_i.carry & bit_v;
            carry_and_inverted_op: exp_c = req_i.carry & !bit_v;
            carry_or_op: exp_c = req_i.carry | bit_v;
            carry_or_inverted_op: exp_c = req_i.carry | !bit_v;
            carry_xor_op: exp_c = req_i.carry ^ bit_v;
            carry_xor_inverted_op: exp_c = req_i.carry ^ !bit_v;
            bit_load_op: exp_c = bit_v;
            bit_load_inverted_op: exp_c = !bit_v;
            default: ;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (acc) addr_q <= req_i.addr;
    end
    reg_data_a: assert property (acc_reg && bmu_writes_operand(req_i.op) |-> ##2 done_o && res_o.reg_we
        && res_o.data == $past(exp_d, 2)) else $error("register byte result wrong");
    reg_carry_a: assert property (acc_reg && bmu_writes_carry(req_i.op) |-> ##2 done_o && res_o.carry_we
        && res_o.carry == $past(exp_c, 2)) else $error("carry result wrong");
    test_zero_a: assert property (acc_reg && req_i.op == test_bit_op |-> ##2 res_o.zero_we && !res_o.reg_we
        && res_o.zero == !$past(bit_v, 2)) else $error("zero flag of bit test wrong");
    bad_pos_a: assert property (acc && bad |=> err_o && !done_o ##1 !done_o) else $error("illegal source not refused");
    reg_pos_a: assert property (acc && req_i.pos_from_reg && !bad |=> !err_o) else $error("register position refused");
    mem_read_a: assert property (acc && req_i.in_mem && !bad |=> mem_req_o && !mem_we_o) else $error("no byte read first");
    mem_addr_a: assert property (mem_req_o |-> mem_addr_o == addr_q) else $error("memory address not the operand");
    mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o)) else $error("memory request dropped");
    done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    err_hold_a: assert property (err_o |-> $stable(res_o) && !done_o) else $error("refused request changed result");
    cover property (done_o && res_o.reg_we);
    cover property (err_o);
    cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule : bmu_bit_unit_chk
bind bmu_bit_unit bmu_bit_unit_chk chk (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_i, .done_o, .err_o,
    .res_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i);
`default_nettype wire

// ---- bmu_pkg.sv ----
// Shared types, constants and helper functions of the bit-manipulation unit
package bmu_pkg;

    localparam int BMU_BYTE_W = 8;
    localparam int BMU_POS_W = 3;
    localparam int BMU_ADDR_W = 16;
    localparam logic [BMU_BYTE_W-1:0] BMU_BYTE_RST = 8'h00;
    localparam logic [BMU_ADDR_W-1:0] BMU_ADDR_RST = 16'h0000;
    localparam logic [BMU_POS_W-1:0] BMU_POS_RST = 3'h0;

    typedef enum logic [3:0] {
        set_bit_op,
        clear_bit_op,
        invert_bit_op,
        test_bit_op,
        carry_and_op,
        carry_and_inverted_op,
        carry_or_op,
        carry_or_inverted_op,
        carry_xor_op,
        carry_xor_inverted_op,
        bit_load_op,
        bit_load_inverted_op,
        bit_store_op,
        bit_store_inverted_op
    } bmu_op_t;

    // One operation as offered by the instruction decoder
    typedef struct packed {
        bmu_op_t op;
        logic pos_from_reg;
        logic [BMU_POS_W-1:0] imm_pos;
        logic [BMU_BYTE_W-1:0] pos_reg;
        logic in_mem;
        logic [BMU_ADDR_W-1:0] addr;
        logic [BMU_BYTE_W-1:0] reg_data;
        logic carry;
        logic zero;
    } bmu_req_t;

    // Outcome handed back to the register file and condition codes
    typedef struct packed {
        logic [BMU_BYTE_W-1:0] data;
        logic carry;
        logic zero;
        logic reg_we;
        logic carry_we;
        logic zero_we;
    } bmu_res_t;

    localparam bmu_res_t BMU_RES_RST = '0;

    function automatic logic [BMU_BYTE_W-1:0] bmu_mask(input logic [BMU_POS_W-1:0] pos);
        bmu_mask = 8'h01 << pos;
    endfunction : bmu_mask

    function automatic logic bmu_writes_operand(input bmu_op_t op);
        bmu_writes_operand = (op == set_bit_op) || (op == clear_bit_op) || (op == invert_bit_op)
            || (op == bit_store_op) || (op == bit_store_inverted_op);
    endfunction : bmu_writes_operand

    function automatic logic bmu_imm_only(input bmu_op_t op);
        bmu_imm_only = (op == carry_and_inverted_op) || (op == carry_or_inverted_op)
            || (op == carry_xor_inverted_op) || (op == bit_load_inverted_op)
            || (op == bit_store_inverted_op);
    endfunction : bmu_imm_only

    function automatic logic bmu_writes_carry(input bmu_op_t op);
        bmu_writes_carry = (op == carry_and_op) || (op == carry_and_inverted_op) || (op == carry_or_op)
            || (op == carry_or_inverted_op) || (op == carry_xor_op) || (op == carry_xor_inverted_op)
            || (op == bit_load_op) || (op == bit_load_inverted_op);
    endfunction : bmu_writes_carry

endpackage : bmu_pkg

// ---- bmu_pos_sel.sv ----
// Bit position source selection and legality check
`timescale 1ns/1ps
`default_nettype none
module bmu_pos_sel (
    // Request fields
    input wire bmu_pkg::bmu_op_t op_i,
    input wire logic pos_from_reg_i,
    input wire logic [bmu_pkg::BMU_POS_W-1:0] imm_pos_i,
    input wire logic [bmu_pkg::BMU_BYTE_W-1:0] pos_reg_i,
    // Selected position
    output logic [bmu_pkg::BMU_POS_W-1:0] pos_o,
    output logic legal_o
);
    import bmu_pkg::*;

    // Only the low three bits of a register count: positions stay in one byte
    assign pos_o = pos_from_reg_i ? pos_reg_i[BMU_POS_W-1:0] : imm_pos_i;
    // Inverted carry, load and store forms take no register position
    assign legal_o = !(pos_from_reg_i && bmu_imm_only(op_i));

endmodule : bmu_pos_sel
`default_nettype wire
